// ---- design/pss_device.sv ----
// System sequencer of the power device: serial slave, sequencer, reset.
// Assumes a host that drives the serial clock and the three enable pins.
//
// What this block does
// - Answer only at slave address 1011010.
// - Single byte writes and reads; never master.
// - Eight bits, MSB first, sampled on rise.
// - Receiver acknowledges every byte.
// - Master opens with START condition.
// - Register 06h: D0 button state, D1 unmask.
// - Software writes D4 only with default.
// - Bits 7:5 and 3:2 read-only, writes ignored.
// - Resistor press requests startup or shutdown.
// - Hard press holds reset until timeout.
// - Reset held low at startup for 260 ms.
// - Interrupt low at startup/unmasked event until polled.
// - Second press sets status; interrupts only if D1 unmask is set.
// - Enables drive rails 1-3; stay on while any.
// - Host disables rails then drops enables.
// - Over-temperature disables all, blocks re-enable.
// - Press starts rail 1, then rails 4, 5.
// - Release reset only when rail 1 good.
// - Stay on by enables; rails 4, 5 follow bits.
// - Early button release shuts device down.
// - Host may delay enables for longer hold.
`timescale 1ns/1ps
`default_nettype none
module pss_device #(
  parameter int RST_CYCLES_P = pss_pkg::RST_CYCLES
) (
  // Clock and reset.
  input  wire logic       clock_i,
  input  wire logic       arst_n_i,
  // Board inputs.
  input  wire logic       push_button_in_n_i,
  input  wire logic       push_button_hard_i,
  input  wire logic       rail1_up_i,
  input  wire logic       rail1_pg_i,
  input  wire logic       over_temp_i,
  // Rail enables, bit 0 is rail 1.
  output logic      [4:0] rail_en_o,
  // Pins to the host.
  pss_if.dev              link
);
  import pss_pkg::*;

  typedef enum logic [2:0] {
    I_IDLE, I_ADDR, I_REG, I_WDATA, I_RDATA
  } pss_i2c_type;
  typedef enum logic [1:0] {
    SQ_OFF, SQ_RAMP, SQ_WAIT, SQ_RUN
  } pss_seq_type;

  // A zero timeout cannot be counted.
  if (RST_CYCLES_P < 1) begin : g_bad_rst
    $error("RST_CYCLES_P must be at least one");
  end

  // ==========================================================================
  // Input synchronisers
  logic [9:0] raw;
  logic [9:0] sync1_r;
  logic [9:0] sync2_r;
  assign raw = {link.scl, link.sda, link.en, push_button_in_n_i,
                push_button_hard_i, rail1_up_i, rail1_pg_i, over_temp_i};

  // Two flops on every pin before any logic looks at it.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_r <= 10'h3ff;
      sync2_r <= 10'h3ff;
    end else begin
      sync1_r <= raw;
      sync2_r <= sync1_r;
    end
  end

  logic       scl_s;
  logic       sda_s;
  logic [2:0] en_s;
  logic       press;
  logic       hard;
  logic       up;
  logic       pg;
  logic       hot;
  assign scl_s = sync2_r[9];
  assign sda_s = sync2_r[8];
  assign en_s  = sync2_r[7:5];
  assign press = !sync2_r[4];  // Low through the resistor is a request.
  assign hard  = sync2_r[3];
  assign up    = sync2_r[2];
  assign pg    = sync2_r[1];
  assign hot   = sync2_r[0];

  // ==========================================================================
  // Serial slave
  pss_i2c_type st_r;
  logic [3:0]  cnt_r;
  logic [7:0]  sh_r;
  logic [7:0]  tx_r;
  logic [7:0]  ptr_r;
  logic        rw_r;
  logic        sda_oe_r;
  logic        scl_d_r;
  logic        sda_d_r;
  logic        unmask_r;
  logic        wexact_r;
  logic        r4_on_r;
  logic        r5_on_r;

  // Bus events seen on the synchronised lines.
  logic        start;
  logic        stop;
  logic        rise;
  logic        fall;
  logic        active;
  logic        adr_hit;
  logic        wr_en;
  logic        rd_done;
  logic [7:0]  rd_byte;
  pss_i2c_type st_after;
  assign start   = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign stop    = scl_s && scl_d_r && !sda_d_r && sda_s;
  assign rise    = scl_s && !scl_d_r;
  assign fall    = !scl_s && scl_d_r;
  assign active  = st_r != I_IDLE;
  assign adr_hit = sh_r[7:1] == DEV_ADDR;
  assign wr_en   = fall && st_r == I_WDATA && cnt_r == ACK_CNT;
  assign rd_done = rise && st_r == I_RDATA && cnt_r == ACK_CNT
                   && ptr_r == REG_SYS;
  assign st_after = (st_r == I_ADDR) ? (rw_r ? I_RDATA : I_REG) :
                    (st_r == I_REG)  ? I_WDATA : st_r;

  // Read mux; read-only bits 7:5 and 3:2 of 06h read as zero.
  assign rd_byte = (ptr_r == REG_SYS) ?
                   {3'h0, wexact_r, 2'h0, unmask_r, press} :
                   (ptr_r == REG_R4) ? {r4_on_r, 7'h00} :
                   (ptr_r == REG_R5) ? {r5_on_r, 7'h00} : 8'h00;

  // Bits shift in on SCL rise; the slave drives only after SCL falls.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r     <= I_IDLE;
      cnt_r    <= 4'h0;
      sh_r     <= 8'h00;
      tx_r     <= 8'h00;
      ptr_r    <= 8'h00;
      rw_r     <= RW_WRITE;
      sda_oe_r <= 1'b0;
    end else if (start) begin
      st_r     <= I_ADDR;
      cnt_r    <= 4'h0;
      sda_oe_r <= 1'b0;
    end else if (stop) begin
      st_r     <= I_IDLE;
      sda_oe_r <= 1'b0;
    end else if (active && rise) begin
      if (cnt_r < ACK_CNT) begin
        sh_r <= {sh_r[6:0], sda_s};
      end
      if (st_r == I_RDATA && cnt_r == ACK_CNT && sda_s) begin
        st_r <= I_IDLE;  // Master NACK ends the read.
      end
      cnt_r <= cnt_r + 4'h1;
    end else if (active && fall) begin
      case (cnt_r)
        ACK_CNT: begin
          if (st_r == I_RDATA) begin
            sda_oe_r <= 1'b0;
          end else if (st_r == I_ADDR && !adr_hit) begin
            st_r <= I_IDLE;
          end else begin
            sda_oe_r <= 1'b1;
            if (st_r == I_ADDR) begin
              rw_r <= sh_r[0];
            end
            if (st_r == I_REG) begin
              ptr_r <= sh_r;
            end
          end
        end
        DONE_CNT: begin
          cnt_r <= 4'h0;
          st_r  <= st_after;
          if (st_after == I_RDATA) begin
            tx_r     <= rd_byte;
            sda_oe_r <= !rd_byte[7];
          end else begin
            sda_oe_r <= 1'b0;
          end
        end
        default: begin
          if (st_r == I_RDATA && cnt_r != 4'h0) begin
            sda_oe_r <= !tx_r[6];
            tx_r     <= {tx_r[6:0], 1'b0};
          end
        end
      endcase
    end
  end

  // Line history for edge detection.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // Writable bits; read-only fields have no storage.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      unmask_r <= UNMASK_RST;
      wexact_r <= WEXACT_RST;
      r4_on_r  <= RON_RST;
      r5_on_r  <= RON_RST;
    end else if (wr_en) begin
      if (ptr_r == REG_SYS) begin
        unmask_r <= sh_r[BIT_UNMASK];
        wexact_r <= sh_r[BIT_WEXACT];
      end
      if (ptr_r == REG_R4) begin
        r4_on_r <= sh_r[BIT_RON];
      end
      if (ptr_r == REG_R5) begin
        r5_on_r <= sh_r[BIT_RON];
      end
    end
  end

  // ==========================================================================
  // Sequencer
  pss_seq_type sq_r;
  logic [4:0]  rails_nxt;
  logic        any_en;
  logic        press_d_r;
  logic        press_rise;
  assign any_en     = |en_s;
  assign press_rise = press && !press_d_r;
  assign rails_nxt  = hot ? RAILS_OFF :
                      (sq_r == SQ_RUN) ? {r5_on_r, r4_on_r, en_s} :
                      (sq_r == SQ_WAIT) ? RAILS_WAIT :
                      (sq_r == SQ_RAMP) ? RAILS_RAMP : RAILS_OFF;

  // Startup sequence A, hold by enables, self shutdown.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sq_r <= SQ_OFF;
    end else if (hot) begin
      sq_r <= SQ_OFF;
    end else begin
      case (sq_r)
        SQ_OFF:  if (press) sq_r <= SQ_RAMP;
        SQ_RAMP: begin
          if (!press) begin
            sq_r <= SQ_OFF;
          end else if (up) begin
            sq_r <= SQ_WAIT;
          end
        end
        SQ_WAIT: begin
          if (any_en) begin
            sq_r <= SQ_RUN;
          end else if (!press) begin
            sq_r <= SQ_OFF;
          end
        end
        SQ_RUN:  if (!any_en) sq_r <= SQ_OFF;
        default: sq_r <= SQ_OFF;
      endcase
    end
  end

  // Rails and button history.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rail_en_o <= RAILS_OFF;
      press_d_r <= 1'b0;
    end else begin
      rail_en_o <= rails_nxt;
      press_d_r <= press;
    end
  end

  // ==========================================================================
  // Reset output and interrupt
  logic        rst_hold;
  logic        rst_act_r;
  logic [31:0] tcnt_r;
  logic        irq_r;
  logic        irq_set;
  assign rst_hold = hard || sq_r == SQ_OFF || sq_r == SQ_RAMP;
  assign irq_set  = (sq_r == SQ_OFF && press && !hot) ||
                    (sq_r == SQ_RUN && press_rise && unmask_r);

  // Timeout counts from the end of the hold, then waits for rail 1 good.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_act_r <= 1'b1;
      tcnt_r    <= 32'h0;
    end else if (rst_hold) begin
      rst_act_r <= 1'b1;
      tcnt_r    <= 32'h0;
    end else if (rst_act_r) begin
      if (tcnt_r != 32'(RST_CYCLES_P - 1)) begin
        tcnt_r <= tcnt_r + 32'h1;
      end else if (pg) begin
        rst_act_r <= 1'b0;
      end
    end
  end

  // Pending interrupt; a new event wins over the clearing read.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_r <= 1'b0;
    end else if (irq_set) begin
      irq_r <= 1'b1;
    end else if (rd_done) begin
      irq_r <= 1'b0;
    end
  end

  assign link.dev_sda_o  = 1'b0;
  assign link.dev_sda_oe = sda_oe_r;
  assign link.dev_rst_o  = 1'b0;
  assign link.dev_rst_oe = rst_act_r;
  assign link.dev_irq_o  = 1'b0;
  assign link.dev_irq_oe = irq_r;
endmodule : pss_device
`default_nettype wire

// ---- design/pss_host.sv ----
// Host end: serial master for single byte transfers, enable pins, and
// an AHB-Lite register slave through which software gives orders.
// Assumes one AHB-Lite master and the sequencer device on the pins.
`timescale 1ns/1ps
`default_nettype none
module pss_host #(
  parameter int QTR_P = pss_pkg::QTR_CYCLES
) (
  // Clock and reset.
  input  wire logic        clock_i,
  input  wire logic        arst_n_i,
  // AHB-Lite slave.
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic  [1:0] htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic  [2:0] hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic      [31:0] hrdata_o,
  // Pins to the device.
  pss_if.host              link
);
  import pss_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} pss_hst_type;

  // The device needs a few cycles to see each line change.
  if (QTR_P < 4) begin : g_bad_qtr
    $error("QTR_P must be at least four");
  end

  // ==========================================================================
  // Pin synchronisers
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_r <= 4'hf;
      sync2_r <= 4'hf;
    end else begin
      sync1_r <= {link.sda, link.rst_n, link.irq_n, link.scl};
      sync2_r <= sync1_r;
    end
  end
  logic sda_s;
  assign sda_s = sync2_r[3];

  // ==========================================================================
  // AHB-Lite slave, zero wait states
  logic             a_ok;
  logic             wr_ph_r;
  logic       [7:0] wa_r;
  logic      [31:0] rd_mux;
  logic             launch;
  logic             busy;
  logic             nack_r;
  logic       [7:0] rx_r;
  logic [EN_W-1:0]  en_r;
  assign a_ok   = hsel_i && htrans_i[1] && hready_i;
  assign rd_mux = (haddr_i[7:0] == A_STAT) ?
                  {20'h0, !sync2_r[2], !sync2_r[1], nack_r, busy, rx_r} :
                  (haddr_i[7:0] == A_EN) ? {29'h0, en_r} : 32'h0;
  assign launch = wr_ph_r && wa_r == A_CMD && hwdata_i[CMD_GO] && !busy;

  // Address phase capture and read data.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ph_r     <= 1'b0;
      wa_r        <= 8'h00;
      hrdata_o    <= 32'h0;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      en_r        <= '0;
    end else begin
      wr_ph_r <= a_ok && hwrite_i;
      wa_r    <= haddr_i[7:0];
      if (a_ok && !hwrite_i) begin
        hrdata_o <= rd_mux;
      end
      if (wr_ph_r && wa_r == A_EN) begin
        en_r <= hwdata_i[EN_W-1:0];
      end
    end
  end

  // ==========================================================================
  // Serial master
  pss_hst_type st_r;
  logic [1:0]  ph_r;
  logic [3:0]  bitc_r;
  logic [1:0]  bi_r;
  logic [7:0]  ptr_r;
  logic [7:0]  wd_r;
  logic        rd_r;
  logic        scl_lo_r;
  logic        sda_lo_r;
  logic [31:0] qcnt_r;
  logic        tick;
  logic        rxm;
  logic [7:0]  tx_byte;
  logic        last;
  assign tick    = qcnt_r == 32'(QTR_P - 1);
  assign busy    = st_r != H_IDLE;
  assign rxm     = rd_r && bi_r == 2'h3;
  assign last    = rd_r ? (bi_r == 2'h3) : (bi_r == 2'h2);
  assign tx_byte = (bi_r == 2'h0) ? {DEV_ADDR, RW_WRITE} :
                   (bi_r == 2'h1) ? ptr_r :
                   rd_r ? {DEV_ADDR, RW_READ} : wd_r;

  // Quarter-bit enable.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      qcnt_r <= 32'h0;
    end else begin
      qcnt_r <= tick ? 32'h0 : qcnt_r + 32'h1;
    end
  end

  // Four quarter phases per bit, START and STOP.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r <= H_IDLE;
      ph_r <= 2'h0;
      bitc_r <= 4'h0;
      bi_r <= 2'h0;
      ptr_r <= 8'h00;
      wd_r <= 8'h00;
      rd_r <= 1'b0;
      nack_r <= 1'b0;
      rx_r <= 8'h00;
      scl_lo_r <= 1'b0;
      sda_lo_r <= 1'b0;
    end else if (launch) begin
      st_r   <= H_START;
      ph_r   <= 2'h0;
      bi_r   <= 2'h0;
      nack_r <= 1'b0;
      rd_r   <= hwdata_i[CMD_RD];
      ptr_r  <= hwdata_i[CMD_PTR_LSB +: 8];
      wd_r   <= hwdata_i[7:0];
    end else if (busy && tick) begin
      ph_r <= ph_r + 2'h1;
      case (st_r)
        H_START: begin
          case (ph_r)
            2'h0: sda_lo_r <= 1'b0;
            2'h1: scl_lo_r <= 1'b0;
            2'h2: sda_lo_r <= 1'b1;
            default: begin
              scl_lo_r <= 1'b1;
              st_r     <= H_BIT;
              bitc_r   <= 4'h0;
            end
          endcase
        end
        H_BIT: begin
          case (ph_r)
            2'h0: sda_lo_r <= !rxm && bitc_r != ACK_CNT
                              && !tx_byte[~bitc_r[2:0]];
            2'h1: scl_lo_r <= 1'b0;
            2'h2: begin
              if (rxm && bitc_r != ACK_CNT) begin
                rx_r <= {rx_r[6:0], sda_s};
              end
              if (!rxm && bitc_r == ACK_CNT && sda_s) begin
                nack_r <= 1'b1;
              end
            end
            default: begin
              scl_lo_r <= 1'b1;
              bitc_r   <= bitc_r + 4'h1;
              if (bitc_r == ACK_CNT) begin
                bitc_r <= 4'h0;
                if (nack_r || last) begin
                  st_r <= H_STOP;
                end else if (rd_r && bi_r == 2'h1) begin
                  st_r <= H_START;
                  bi_r <= 2'h2;
                end else begin
                  bi_r <= bi_r + 2'h1;
                end
              end
            end
          endcase
        end
        H_STOP: begin
          case (ph_r)
            2'h0: sda_lo_r <= 1'b1;
            2'h1: scl_lo_r <= 1'b0;
            2'h2: sda_lo_r <= 1'b0;
            default: st_r <= H_IDLE;
          endcase
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end

  assign link.host_scl_o  = 1'b0;
  assign link.host_scl_oe = scl_lo_r;
  assign link.host_sda_o  = 1'b0;
  assign link.host_sda_oe = sda_lo_r;
  assign link.en          = en_r;
endmodule : pss_host
`default_nettype wire

// ---- design/pss_if.sv ----
// Pins between the sequencer device and its host processor.
// Open-drain wires resolve here; pull-ups are implied.
`timescale 1ns/1ps
`default_nettype none
interface pss_if;
  // ==========================================================================
  // Drives from both ends
  logic       host_scl_o;
  logic       host_scl_oe;
  logic       host_sda_o;
  logic       host_sda_oe;
  logic       dev_sda_o;
  logic       dev_sda_oe;
  logic       dev_rst_o;
  logic       dev_rst_oe;
  logic       dev_irq_o;
  logic       dev_irq_oe;
  logic [2:0] en;
  logic       scl;
  logic       sda;
  logic       rst_n;
  logic       irq_n;

  // Wired-AND levels with pull-ups.
  assign scl   = !(host_scl_oe && !host_scl_o);
  assign sda   = !(host_sda_oe && !host_sda_o) && !(dev_sda_oe && !dev_sda_o);
  assign rst_n = !(dev_rst_oe && !dev_rst_o);
  assign irq_n = !(dev_irq_oe && !dev_irq_o);

  modport dev (input scl, sda, en,
               output dev_sda_o, dev_sda_oe, dev_rst_o, dev_rst_oe,
               dev_irq_o, dev_irq_oe);
  modport host (input scl, sda, rst_n, irq_n,
                output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe, en);
endinterface : pss_if
`default_nettype wire

// ---- design/pss_pkg.sv ----
// Shared constants of the system sequencer and its serial-port host.
// Assumes a 100 MHz system clock on both ends.
package pss_pkg;
  // ==========================================================================
  // Serial link
  localparam logic [6:0] DEV_ADDR   = 7'h5a;
  localparam logic       RW_WRITE   = 1'b0;
  localparam logic       RW_READ    = 1'b1;
  localparam logic [3:0] ACK_CNT    = 4'h8;  // Bits seen when ACK is due.
  localparam logic [3:0] DONE_CNT   = 4'h9;  // Bits seen after the ACK.
  localparam int         SCL_PERIOD_NS = 2500;
  localparam int         CLK_PERIOD_NS = 10;
  localparam int         QTR_CYCLES =
    (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);

  // ==========================================================================
  // Device registers
  localparam logic [7:0] REG_SYS    = 8'h06;
  localparam logic [7:0] REG_R4     = 8'h40;
  localparam logic [7:0] REG_R5     = 8'h41;
  localparam int         BIT_PB     = 0;
  localparam int         BIT_UNMASK = 1;
  localparam int         BIT_WEXACT = 4;
  localparam int         BIT_RON    = 7;
  localparam logic       UNMASK_RST = 1'b1;
  localparam logic       WEXACT_RST = 1'b0;
  localparam logic       RON_RST    = 1'b1;

  // ==========================================================================
  // Sequencing and reset timing
  localparam int RST_TIMEOUT_MS = 260;
  localparam int CLK_KHZ        = 1000000 / CLK_PERIOD_NS;
  localparam int RST_CYCLES     = RST_TIMEOUT_MS * CLK_KHZ;
  localparam logic [4:0] RAILS_OFF  = 5'h00;
  localparam logic [4:0] RAILS_RAMP = 5'h01;  // Rail 1 only.
  localparam logic [4:0] RAILS_WAIT = 5'h19;  // Rails 1, 4 and 5.

  // ==========================================================================
  // Host registers on AHB-Lite
  localparam logic [7:0] A_CMD   = 8'h00;
  localparam logic [7:0] A_STAT  = 8'h04;
  localparam logic [7:0] A_EN    = 8'h08;
  localparam int CMD_GO      = 31;
  localparam int CMD_RD      = 16;
  localparam int CMD_PTR_LSB = 8;
  localparam int ST_BUSY     = 8;
  localparam int ST_NACK     = 9;
  localparam int ST_IRQ      = 10;
  localparam int ST_RST      = 11;
  localparam int EN_W        = 3;
endpackage : pss_pkg

// ---- testbench/pss_chk.sv ----
// Checker of the pins between the sequencer device and its host.
// Assumes tb instantiates it beside the interface with its parameters.
`timescale 1ns/1ps
`default_nettype none
module pss_chk #(
  parameter int RST_P = 200
) (
  // Clock, reset and interface wires.
  input wire logic       clock_i,
  input wire logic       arst_n_i,
  input wire logic       scl,
  input wire logic       sda,
  input wire logic       rst_n,
  input wire logic       irq_n,
  input wire logic       dev_sda_oe,
  input wire logic       host_sda_oe,
  // Device board ports.
  input wire logic       push_button_hard_i,
  input wire logic       rail1_pg_i,
  input wire logic       over_temp_i,
  input wire logic [4:0] rail_en_o
);
  import pss_pkg::*;
  // ==========================================================
  // Properties, all on the system clock.
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!arst_n_i);
  property p_start; $fell(sda) && scl && $past(scl) |-> host_sda_oe; endproperty
  a_start: assert property (p_start) else $error("sda fell in scl high");
  property p_dev; $changed(dev_sda_oe) |-> !scl && !$past(scl); endproperty
  a_dev: assert property (p_dev) else $error("device sda moved");
  property p_clash; dev_sda_oe && scl |-> !host_sda_oe; endproperty
  a_clash: assert property (p_clash) else $error("both pull sda");
  property p_rst; $rose(rst_n) |-> !$past(rst_n, RST_P); endproperty
  a_rst: assert property (p_rst) else $error("reset too short");
  property p_pg; $rose(rst_n) |-> $past(rail1_pg_i, 3); endproperty
  a_pg: assert property (p_pg) else $error("reset freed, rail bad");
  property p_irq; $rose(irq_n) |-> scl; endproperty
  a_irq: assert property (p_irq) else $error("irq freed off poll");
  property p_hard; $rose(push_button_hard_i) |=> ##[0:4] !rst_n; endproperty
  a_hard: assert property (p_hard) else $error("no hard reset");
  property p_hot; $rose(over_temp_i) |-> ##[1:6] rail_en_o == RAILS_OFF; endproperty
  a_hot: assert property (p_hot) else $error("rails on when hot");
  // Main scenarios seen.
  c_rst: cover property ($rose(rst_n));
  c_irq: cover property ($fell(irq_n));
  c_ack: cover property (dev_sda_oe && scl);
endmodule : pss_chk
`default_nettype wire

// ---- testbench/tb.sv ----
// Bench: device and host on one pin interface, driven over AHB-Lite.
// Assumes shortened reset and serial timings through parameters.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pss_pkg::*;
  localparam int RST = 200;
  logic        clock_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        pb_n = 1'b1, hard = 1'b0, up = 1'b0, pg = 1'b0, ot = 1'b0;
  logic        hwrite = 1'b0, hready, hresp;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [4:0]  rail;
  int          miscompares = 0, n_compared = 0;
  pss_if i_pss_if ();
  // ==========================================================
  // Design ends and checker.
  pss_device #(.RST_CYCLES_P(RST)) i_pss_device (.clock_i(clock_i),
    .arst_n_i(arst_n_i), .push_button_in_n_i(pb_n),
    .push_button_hard_i(hard), .rail1_up_i(up), .rail1_pg_i(pg),
    .over_temp_i(ot), .rail_en_o(rail), .link(i_pss_if));
  pss_host #(.QTR_P(8)) i_pss_host (.clock_i(clock_i),
    .arst_n_i(arst_n_i), .hsel_i(1'b1), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready),
    .hresp_o(hresp), .hrdata_o(hrdata), .link(i_pss_if));
  pss_chk #(.RST_P(RST)) i_pss_chk (.clock_i(clock_i),
    .arst_n_i(arst_n_i), .scl(i_pss_if.scl), .sda(i_pss_if.sda),
    .rst_n(i_pss_if.rst_n), .irq_n(i_pss_if.irq_n),
    .dev_sda_oe(i_pss_if.dev_sda_oe),
    .host_sda_oe(i_pss_if.host_sda_oe), .push_button_hard_i(hard),
    .rail1_pg_i(pg), .over_temp_i(ot), .rail_en_o(rail));
  // Free-running 100 MHz clock.
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  // Bench tasks: waits, compares and bus cycles.
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask : cyc
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: %h, expected %h", $time, g, e);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    cyc(1);
    while (hready !== 1'b1) cyc(1);
    htrans <= 2'h0;
    hwdata <= d;
    cyc(1);
    while (hready !== 1'b1) cyc(1);
    q = hrdata;
  endtask : ahb
  task automatic st(input int b, input logic e);
    ahb(1'b0, A_STAT, 32'h0);
    chk(q[b], e);
  endtask : st
  // Serial transfer by command; busy is polled a bounded number of times.
  task automatic xfer(input logic r, input logic [7:0] p,
                      input logic [7:0] d);
    ahb(1'b1, A_CMD, {1'b1, 14'h0, r, p, d});
    cyc(4);
    q = 32'h100;
    for (int i = 0; i < 3000 && q[ST_BUSY] !== 1'b0; i++)
      ahb(1'b0, A_STAT, 32'h0);
    chk(q[ST_BUSY], 1'b0);
  endtask : xfer
  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    xfer(1'b1, p, 8'h0);
    chk(q[ST_NACK], 1'b0);
    chk(q[7:0], e);
  endtask : rd
  task automatic results;
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results
  // Watchdog against a hang.
  initial begin
    cyc(80000);
    miscompares++;
    results;
  end
  // Main sequence.
  initial begin
    cyc(8);
    arst_n_i <= 1'b1;
    cyc(2);
    st(ST_RST, 1'b1);
    pb_n <= 1'b0;
    cyc(8);
    chk(rail, RAILS_RAMP);
    st(ST_IRQ, 1'b1);
    up <= 1'b1;
    cyc(RST + 20);
    chk(rail, RAILS_WAIT);
    st(ST_RST, 1'b1);
    pg <= 1'b1;
    cyc(8);
    st(ST_RST, 1'b0);
    ahb(1'b1, A_EN, 32'h1);
    cyc(8);
    pb_n <= 1'b1;
    cyc(8);
    chk(rail, 5'h19);
    ahb(1'b0, 8'h0c, 32'h0);
    chk(q, 32'h0);
    chk(hresp, 1'b0);
    $display("test startup done");
    rd(REG_SYS, 8'h02);
    st(ST_IRQ, 1'b0);
    xfer(1'b0, REG_SYS, 8'hec);
    rd(REG_SYS, 8'h00);
    pb_n <= 1'b0;
    cyc(8);
    st(ST_IRQ, 1'b0);
    pb_n <= 1'b1;
    xfer(1'b0, REG_SYS, 8'h02);
    pb_n <= 1'b0;
    cyc(8);
    st(ST_IRQ, 1'b1);
    rd(REG_SYS, 8'h03);
    pb_n <= 1'b1;
    xfer(1'b0, REG_R4, 8'h00);
    cyc(8);
    chk(rail, 5'h11);
    $display("test register done");
    ahb(1'b1, A_EN, 32'h6);
    cyc(8);
    chk(rail, 5'h16);
    hard <= 1'b1;
    cyc(8);
    st(ST_RST, 1'b1);
    hard <= 1'b0;
    cyc(RST - 20);
    st(ST_RST, 1'b1);
    cyc(40);
    st(ST_RST, 1'b0);
    ahb(1'b1, A_EN, 32'h0);
    cyc(8);
    chk(rail, RAILS_OFF);
    pb_n <= 1'b0;
    cyc(8);
    pb_n <= 1'b1;
    cyc(8);
    chk(rail, RAILS_OFF);
    ot <= 1'b1;
    pb_n <= 1'b0;
    cyc(10);
    chk(rail, RAILS_OFF);
    pb_n <= 1'b1;
    ot <= 1'b0;
    $display("test shutdown done");
    results;
  end
endmodule : tb
`default_nettype wire
